/* File: pkg/cansbt_consts.svh */
`ifndef CANSBT_CONSTS_SVH
`define CANSBT_CONSTS_SVH

// ****************************************************
// register offsets (byte addresses)
// ****************************************************
`define CANSBT_ADDR_W 8
`define CANSBT_OFF_STATUS 8'h00
`define CANSBT_OFF_TIMING 8'h04
`define CANSBT_OFF_MODE 8'h08
`define CANSBT_OFF_MASK 8'h0c
`define CANSBT_OFF_TIMER 8'h10

// ****************************************************
// status field positions
// ****************************************************
`define CANSBT_SR_MB_LSB 0
`define CANSBT_SR_MB_MSB 7
`define CANSBT_SR_ERRACT 16
`define CANSBT_SR_WARN 17
`define CANSBT_SR_ERRPAS 18
`define CANSBT_SR_BUSOFF 19
`define CANSBT_SR_SLEEP 20
`define CANSBT_SR_WAKE 21
`define CANSBT_SR_TROLL 22
`define CANSBT_SR_FMARK 23
`define CANSBT_SR_CRC 24
`define CANSBT_SR_STUFF 25
`define CANSBT_SR_ACK 26
`define CANSBT_SR_FORM 27
`define CANSBT_SR_BIT 28
`define CANSBT_SR_RXACT 29
`define CANSBT_SR_TXACT 30
`define CANSBT_SR_OVLACT 31
// read-clear flags: rollover, frame mark and the five faults
`define CANSBT_SR_RC_MASK 32'h1fc00000
// implemented status bits; 8..15 read as zero
`define CANSBT_SR_IMPL_MASK 32'hffff00ff

// ****************************************************
// bit-timing, mode and mask layouts
// ****************************************************
`define CANSBT_BT_WR_MASK 32'h017f3777
`define CANSBT_BT_RESET 32'h00000000
`define CANSBT_MODE_ENABLE 0
`define CANSBT_MODE_LOWPWR 1
`define CANSBT_MODE_CAPEOF 2
`define CANSBT_MODE_WR_MASK 32'h00000007
`define CANSBT_MASK_WR_MASK 32'h1fff00ff

// ****************************************************
// error-count thresholds and timer maximum
// ****************************************************
`define CANSBT_WARN_LIMIT 9'd96
`define CANSBT_PASSIVE_LIMIT 9'd128
`define CANSBT_BUSOFF_LIMIT 9'd256
`define CANSBT_TIMER_MAX 16'hffff

`endif

/* File: pkg/cansbt_pkg.sv */
package cansbt_pkg;

  // bit-timing configuration, laid out as the register
  typedef struct packed {
    logic [6:0] rsv_hi;
    logic triple_sampling;
    logic rsv_23;
    logic [6:0] prescale_value;
    logic [1:0] rsv_15;
    logic [1:0] resync_jump_width;
    logic rsv_11;
    logic [2:0] network_delay_segment;
    logic rsv_7;
    logic [2:0] first_phase_segment;
    logic rsv_3;
    logic [2:0] second_phase_segment;
  } cansbt_timing_t;

  // protocol events and activity levels from the bit engine
  typedef struct packed {
    logic crc_fault;
    logic stuff_fault;
    logic ack_fault;
    logic form_fault;
    logic bit_fault;
    logic start_of_frame;
    logic end_of_frame;
    logic wake_event;
    logic timer_tick;
    logic rx_active;
    logic tx_active;
    logic overload_active;
  } cansbt_events_t;

  // error counters from the confinement logic
  typedef struct packed {
    logic [8:0] tx_error_count;
    logic [7:0] rx_error_count;
  } cansbt_counts_t;

  // controller mode as seen by the core
  typedef struct packed {
    logic enabled;
    logic low_power;
    logic triple_sampling;
  } cansbt_mode_t;

endpackage

/* File: hw/cansbt_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// - Status low byte holds one event bit per mailbox, ready or abort.
// - Error-active bit 16 high unless passive or bus off; self-clearing.
// - Warning bit set while either error count exceeds 96.
// - Error-passive bit set while either count is at least 128.
// - Bus-off bit set while transmit count is 256 or more.
// - Low-power bit 20 set while in low-power mode, cleared on exit.
// - Wake event resumes traffic, sets bit 21; low-power entry clears it.
// - Timer rollover from maximum to zero sets flag; status read clears.
// - Frame-mark bit 23 set on start of frame, or on end of frame with capture-at-frame-end; read clears.
// - CRC-fault bit 24 set on CRC mismatch; read clears.
// - Stuff-fault bit 25 set on six equal bits; read clears.
// - Ack-fault bit 26 set when ack slot stays recessive; read clears.
// - Form-fault bit 27 set on fixed-form field violation; read clears.
// - Bit-fault bit 28 set when monitored level differs; read clears.
// - Receive-active bit 29 follows receiver busy with any frame.
// - Transmit-active bit 30 follows transmitter busy with any frame.
// - Overload-active bit 31 high only while sending an overload frame.
// - Interrupt asserted while any set flag has its mask bit set.
`include "cansbt_consts.svh"

module cansbt_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CANSBT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] mailbox_ready_flag,
  input wire logic [7:0] mailbox_abort_flag,
  input wire cansbt_pkg::cansbt_counts_t counts_i,
  input wire cansbt_pkg::cansbt_events_t events_i,
  output cansbt_pkg::cansbt_timing_t timing_o,
  output cansbt_pkg::cansbt_mode_t mode_o,
  output logic [15:0] timer_o,
  output logic irq
);
  import cansbt_pkg::*;

  // ****************************************************
  // decode helpers
  // ****************************************************

  // true for every mapped register offset
  function automatic logic addr_mapped(input logic [`CANSBT_ADDR_W-1:0] a);
    addr_mapped = (a == `CANSBT_OFF_STATUS) || (a == `CANSBT_OFF_TIMING) ||
                  (a == `CANSBT_OFF_MODE) || (a == `CANSBT_OFF_MASK) ||
                  (a == `CANSBT_OFF_TIMER);
  endfunction

  // true when the address equals one offset
  function automatic logic hit(input logic [`CANSBT_ADDR_W-1:0] a,
                               input logic [`CANSBT_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ****************************************************
  // bus handshake
  // ****************************************************
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;

  assign access = psel & penable;
  assign done = access & pready_q;
  assign wr_done = done & pwrite & ~pslverr_q;
  assign rd_done = done & ~pwrite & ~pslverr_q;

  // every access takes one wait state, then completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (access && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= ~addr_mapped(paddr);
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ****************************************************
  // software registers
  // ****************************************************
  logic [31:0] timing_q;
  logic [31:0] mode_q;
  logic [31:0] mask_q;

  // bit-timing config; unused bits held at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_q <= `CANSBT_BT_RESET;
    end else if (wr_done && hit(paddr, `CANSBT_OFF_TIMING)) begin
      timing_q <= pwdata & `CANSBT_BT_WR_MASK;
    end
  end

  // mode: enable, low-power request, capture at frame end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 32'h00000000;
    end else if (wr_done && hit(paddr, `CANSBT_OFF_MODE)) begin
      mode_q <= pwdata & `CANSBT_MODE_WR_MASK;
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 32'h00000000;
    end else if (wr_done && hit(paddr, `CANSBT_OFF_MASK)) begin
      mask_q <= pwdata & `CANSBT_MASK_WR_MASK;
    end
  end

  // ****************************************************
  // low-power and wake-up
  // ****************************************************
  logic sleep_q;
  logic wake_q;
  logic lp_req_q;
  logic lp_req;

  assign lp_req = mode_q[`CANSBT_MODE_LOWPWR];

  // edge of the low-power request enters low power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_req_q <= 1'b0;
    end else begin
      lp_req_q <= lp_req;
    end
  end

  // sleep follows the mode; a wake event leaves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else if (!lp_req) begin
      sleep_q <= 1'b0;
    end else if (events_i.wake_event && sleep_q) begin
      sleep_q <= 1'b0;
    end else if (!lp_req_q) begin
      sleep_q <= 1'b1;
    end
  end

  // bus-resumed flag: set by wake, cleared on low-power entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else if (events_i.wake_event && sleep_q) begin
      wake_q <= 1'b1;
    end else if (lp_req && !lp_req_q) begin
      wake_q <= 1'b0;
    end
  end

  // ****************************************************
  // internal timer
  // ****************************************************
  logic [15:0] timer_q;
  logic roll;

  assign roll = events_i.timer_tick && (timer_q == `CANSBT_TIMER_MAX);

  // free-running 16-bit count on the bit-time tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= 16'h0000;
    end else if (!mode_q[`CANSBT_MODE_ENABLE]) begin
      timer_q <= 16'h0000;
    end else if (events_i.timer_tick) begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  // ****************************************************
  // status flags
  // ****************************************************
  logic [31:0] sticky_q;
  logic [31:0] set_ev;
  logic [31:0] clr_ev;
  logic [31:0] live_q;
  logic [31:0] status;
  logic frame_ev;

  // frame mark source picked by capture-at-frame-end
  assign frame_ev = mode_q[`CANSBT_MODE_CAPEOF] ? events_i.end_of_frame :
                    events_i.start_of_frame;

  // one-cycle set requests for read-clear flags
  always_comb begin
    set_ev = 32'h00000000;
    set_ev[`CANSBT_SR_TROLL] = roll;
    set_ev[`CANSBT_SR_FMARK] = frame_ev;
    set_ev[`CANSBT_SR_CRC] = events_i.crc_fault;
    set_ev[`CANSBT_SR_STUFF] = events_i.stuff_fault;
    set_ev[`CANSBT_SR_ACK] = events_i.ack_fault;
    set_ev[`CANSBT_SR_FORM] = events_i.form_fault;
    set_ev[`CANSBT_SR_BIT] = events_i.bit_fault;
  end

  // clear only what the read actually returned
  assign clr_ev = rd_done && hit(paddr, `CANSBT_OFF_STATUS) ?
                  (prdata_q & `CANSBT_SR_RC_MASK) : 32'h00000000;

  // read-clear flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_q <= 32'h00000000;
    end else begin
      sticky_q <= ((sticky_q & ~clr_ev) | set_ev) & `CANSBT_SR_RC_MASK;
    end
  end

  // level flags follow their sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_q <= 32'h00000000;
    end else begin
      live_q <= 32'h00000000;
      for (int i = 0; i < 8; i++) begin
        live_q[`CANSBT_SR_MB_LSB + i] <= mailbox_ready_flag[i] |
                                         mailbox_abort_flag[i];
      end
      live_q[`CANSBT_SR_WARN] <=
        (counts_i.tx_error_count > `CANSBT_WARN_LIMIT) ||
        ({1'b0, counts_i.rx_error_count} > `CANSBT_WARN_LIMIT);
      live_q[`CANSBT_SR_ERRPAS] <=
        (counts_i.tx_error_count >= `CANSBT_PASSIVE_LIMIT) ||
        ({1'b0, counts_i.rx_error_count} >= `CANSBT_PASSIVE_LIMIT);
      live_q[`CANSBT_SR_BUSOFF] <=
        (counts_i.tx_error_count >= `CANSBT_BUSOFF_LIMIT);
      live_q[`CANSBT_SR_ERRACT] <=
        !((counts_i.tx_error_count >= `CANSBT_PASSIVE_LIMIT) ||
          ({1'b0, counts_i.rx_error_count} >= `CANSBT_PASSIVE_LIMIT));
      live_q[`CANSBT_SR_RXACT] <= events_i.rx_active;
      live_q[`CANSBT_SR_TXACT] <= events_i.tx_active;
      live_q[`CANSBT_SR_OVLACT] <= events_i.overload_active &&
                                   events_i.tx_active;
    end
  end

  // assembled status word; bits 8..15 stay zero
  always_comb begin
    status = (live_q | sticky_q) & `CANSBT_SR_IMPL_MASK;
    status[`CANSBT_SR_SLEEP] = sleep_q;
    status[`CANSBT_SR_WAKE] = wake_q;
  end

  // ****************************************************
  // read data capture
  // ****************************************************

  // sample the addressed register in the wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (access && !pready_q && !pwrite) begin
      unique case (paddr)
        `CANSBT_OFF_STATUS: prdata_q <= status;
        `CANSBT_OFF_TIMING: prdata_q <= timing_q;
        `CANSBT_OFF_MODE: prdata_q <= mode_q;
        `CANSBT_OFF_MASK: prdata_q <= mask_q;
        `CANSBT_OFF_TIMER: prdata_q <= {16'h0000, timer_q};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************
  // core-facing outputs
  // ****************************************************
  cansbt_timing_t timing_out_q;
  cansbt_mode_t mode_out_q;
  logic irq_q;
  logic [15:0] timer_out_q;

  // timing out; triple sampling off when prescale is zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_out_q <= cansbt_timing_t'(`CANSBT_BT_RESET);
    end else begin
      timing_out_q <= cansbt_timing_t'(timing_q);
      timing_out_q.triple_sampling <= timing_q[24] && (timing_q[22:16] != 7'h00);
    end
  end

  // traffic allowed while enabled and awake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_out_q <= '0;
    end else begin
      mode_out_q.enabled <= mode_q[`CANSBT_MODE_ENABLE] && !sleep_q;
      mode_out_q.low_power <= sleep_q;
      mode_out_q.triple_sampling <= timing_q[24] && (timing_q[22:16] != 7'h00);
    end
  end

  // interrupt while any flag meets its mask bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status & mask_q);
    end
  end

  // timer value for the timestamp capture logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out_q <= 16'h0000;
    end else begin
      timer_out_q <= timer_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timing_o = timing_out_q;
  assign mode_o = mode_out_q;
  assign timer_o = timer_out_q;
  assign irq = irq_q;

endmodule

/* File: dv/cansbt_regs_properties.sv */
`timescale 1ns/1ps
`include "cansbt_consts.svh"

// ****************************************
// status and timing register checker
// ****************************************
module cansbt_regs_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CANSBT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] mailbox_ready_flag,
  input wire logic [7:0] mailbox_abort_flag,
  input wire cansbt_pkg::cansbt_counts_t counts_i,
  input wire cansbt_pkg::cansbt_events_t events_i,
  input wire cansbt_pkg::cansbt_timing_t timing_o
);
  import cansbt_pkg::*;
  logic [35:0] lvl_q;
  logic [2:0] stab_q;
  logic tw_q;
  logic [31:0] tw_exp_q;
  logic [35:0] lvl;
  logic [8:0] tx;
  logic [8:0] rx;
  logic rd_sr;
  logic still;
  logic mapped;
  logic tw_hit;
  // decoded views of the watched ports
  assign lvl = {mailbox_ready_flag, mailbox_abort_flag, counts_i, events_i[2:0]};
  assign tx = counts_i.tx_error_count;
  assign rx = {1'b0, counts_i.rx_error_count};
  assign rd_sr = pready && !pwrite && paddr == `CANSBT_OFF_STATUS;
  assign still = stab_q >= 3'd4;
  assign mapped = paddr[1:0] == 2'b00 && paddr <= `CANSBT_OFF_TIMER;
  assign tw_hit = pready && pwrite && paddr == `CANSBT_OFF_TIMING;
  // cycles the live levels have held still
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= '0;
      stab_q <= '0;
    end else begin
      lvl_q <= lvl;
      if (lvl_q != lvl) begin
        stab_q <= '0;
      end else if (stab_q != 3'd7) begin
        stab_q <= stab_q + 3'd1;
      end
    end
  end
  // expected timing output after a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tw_q <= 1'b0;
      tw_exp_q <= '0;
    end else begin
      tw_q <= tw_hit;
      if (tw_hit) begin
        tw_exp_q <= pwdata & `CANSBT_BT_WR_MASK & ~{7'h0, pwdata[22:16] == 7'h0, 24'h0};
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (pready && !pwrite && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr)
    else $error("error on mapped access");
  a_status_gap: assert property (rd_sr |-> prdata[15:8] == 8'h00)
    else $error("status gap bits not zero");
  a_timing_rsv: assert property (pready && !pwrite && paddr == `CANSBT_OFF_TIMING |->
    (prdata & ~`CANSBT_BT_WR_MASK) == 32'h0)
    else $error("timing reserved bits not zero");
  a_timing_out: assert property (tw_q |-> ##[0:2] timing_o == tw_exp_q)
    else $error("timing output does not follow write");
  a_mailbox_evt: assert property (rd_sr && still |->
    prdata[7:0] == (mailbox_ready_flag | mailbox_abort_flag))
    else $error("mailbox event bits wrong");
  a_conf_state: assert property (rd_sr && still |->
    prdata[16] == (tx < 9'd128 && rx < 9'd128) && prdata[18] == (tx >= 9'd128 || rx >= 9'd128)
    && prdata[19] == (tx >= 9'd256))
    else $error("confinement flags wrong");
  a_warn_limit: assert property (rd_sr && still |->
    prdata[17] == (tx > `CANSBT_WARN_LIMIT || rx > `CANSBT_WARN_LIMIT))
    else $error("warning flag wrong");
  a_busy_flags: assert property (rd_sr && still |->
    prdata[31:29] == {events_i.overload_active & events_i.tx_active, events_i.tx_active,
    events_i.rx_active})
    else $error("activity flags wrong");
endmodule

bind cansbt_regs cansbt_regs_props u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .mailbox_ready_flag, .mailbox_abort_flag, .counts_i, .events_i, .timing_o
);

/* File: dv/cansbt_engine_model.sv */
`timescale 1ns/1ps

// ****************************************
// protocol engine stand-in
// ****************************************
module cansbt_engine_model (
  input wire logic pclk,
  input wire logic [8:0] fire,
  input wire logic tick_run,
  input wire logic [2:0] lv,
  input wire logic [8:0] tx_cnt,
  input wire logic [7:0] rx_cnt,
  input wire logic [15:0] mb,
  output cansbt_pkg::cansbt_events_t events_o,
  output cansbt_pkg::cansbt_counts_t counts_o,
  output logic [7:0] rdy_o,
  output logic [7:0] abt_o
);
  import cansbt_pkg::*;
  // quiet outputs before the first edge
  initial begin
    events_o = '0;
    counts_o = '0;
    rdy_o = '0;
    abt_o = '0;
  end
  // one-cycle pulses and levels; clock keeps running for wake events
  always @(posedge pclk) begin
    events_o <= {fire[8:1], fire[0] | tick_run, lv};
    counts_o <= {tx_cnt, rx_cnt};
    rdy_o <= mb[15:8];
    abt_o <= mb[7:0];
  end
endmodule

/* File: dv/can_status_and_bit_timing_regs_tb.sv */
`timescale 1ns/1ps
`include "cansbt_consts.svh"

// ****************************************
// register block bench
// ****************************************
module can_status_and_bit_timing_regs_tb;
  import cansbt_pkg::*;
  typedef struct {
    logic [8:0] tx;
    logic [7:0] rx;
    logic [15:0] mb;
    logic [2:0] lv;
    logic [31:0] sr;
  } cansbt_row_t;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0, tick_run = 0;
  logic pready, pslverr, irq, er;
  logic [7:0] paddr = '0, rx_cnt = '0, rdy, abt;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [8:0] fire = '0, tx_cnt = '0;
  logic [2:0] lv = '0;
  logic [15:0] mb = '0, tmr;
  cansbt_events_t ev;
  cansbt_counts_t cnt;
  cansbt_timing_t tmg;
  cansbt_mode_t mode;
  int n_fail = 0, compares = 0, cyc = 0;
  // level cases: counts, mailbox flags, activity, whole status word
  cansbt_row_t rows [9] = '{
    '{9'd0, 8'd0, 16'h0000, 3'b000, 32'h00010000},
    '{9'd96, 8'd96, 16'h8001, 3'b100, 32'h20010081},
    '{9'd97, 8'd0, 16'h0100, 3'b010, 32'h40030001},
    '{9'd0, 8'd97, 16'h00f0, 3'b011, 32'hc00300f0},
    '{9'd127, 8'd127, 16'h0000, 3'b001, 32'h00030000},
    '{9'd128, 8'd0, 16'hff00, 3'b111, 32'he00600ff},
    '{9'd255, 8'd128, 16'h00ff, 3'b000, 32'h000600ff},
    '{9'd256, 8'd0, 16'h0000, 3'b000, 32'h000e0000},
    '{9'd511, 8'd255, 16'h5a5a, 3'b000, 32'h000e005a}};

  cansbt_regs DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mailbox_ready_flag(rdy), .mailbox_abort_flag(abt), .counts_i(cnt), .events_i(ev),
    .timing_o(tmg), .mode_o(mode), .timer_o(tmr), .irq);
  cansbt_engine_model u_far (
    .pclk, .fire, .tick_run, .lv, .tx_cnt, .rx_cnt, .mb,
    .events_o(ev), .counts_o(cnt), .rdy_o(rdy), .abt_o(abt));

  // clock and hang guard
  initial begin
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) begin
      n_fail++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one-cycle event from the engine stand-in
  task automatic pulse(input int i);
    @(posedge pclk);
    fire <= 9'h1 << i;
    @(posedge pclk);
    fire <= '0;
  endtask

  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      @(posedge pclk);
      tx_cnt <= rows[i].tx;
      rx_cnt <= rows[i].rx;
      mb <= rows[i].mb;
      lv <= rows[i].lv;
      repeat (6) @(posedge pclk);
      apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
      chk32(rd, rows[i].sr);
    end
    tx_cnt <= '0;
    rx_cnt <= '0;
    mb <= '0;
    lv <= '0;
    $display("level table done");
    apb(1'b0, `CANSBT_OFF_TIMING, 32'h0);
    chk32(rd, `CANSBT_BT_RESET);
    apb(1'b1, `CANSBT_OFF_TIMING, 32'hffffffff);
    apb(1'b0, `CANSBT_OFF_TIMING, 32'h0);
    chk32(rd, 32'h017f3777);
    chk32(tmg, 32'h017f3777);
    apb(1'b0, 8'h14, 32'h0);
    chk32({rd[30:0], er}, 32'h1);
    apb(1'b1, `CANSBT_OFF_STATUS, 32'hffffffff);
    apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
    chk32(rd, 32'h00010000);
    $display("timing and refusal done");
    for (int i = 3; i <= 8; i++) begin
      pulse(i);
      apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
      chk32(rd, 32'h00010000 | (32'h1 << ((i == 3) ? 23 : 32 - i)));
      apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
      chk32(rd, 32'h00010000);
    end
    apb(1'b1, `CANSBT_OFF_MODE, 32'h4);
    pulse(3);
    pulse(2);
    apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
    chk32(rd, 32'h00810000);
    apb(1'b1, `CANSBT_OFF_MODE, 32'h0);
    fork
      apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
      pulse(8);
    join
    chk32(rd, 32'h00010000);
    apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
    chk32(rd, 32'h01010000);
    $display("read-clear flags done");
    apb(1'b1, `CANSBT_OFF_MODE, 32'h1);
    tick_run <= 1'b1;
    repeat (65536) @(posedge pclk);
    tick_run <= 1'b0;
    repeat (4) @(posedge pclk);
    chk32({16'h0, tmr}, 32'h0);
    apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
    chk32(rd, 32'h00410000);
    apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
    chk32(rd, 32'h00010000);
    $display("timer rollover done");
    apb(1'b1, `CANSBT_OFF_MODE, 32'h3);
    apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
    chk32(rd, 32'h00110000);
    chk32({31'h0, mode.low_power}, 32'h1);
    chk32({31'h0, mode.enabled}, 32'h0);
    pulse(1);
    apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
    chk32(rd, 32'h00210000);
    chk32({31'h0, mode.enabled}, 32'h1);
    apb(1'b1, `CANSBT_OFF_MODE, 32'h1);
    apb(1'b1, `CANSBT_OFF_MODE, 32'h3);
    apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
    chk32(rd, 32'h00110000);
    apb(1'b1, `CANSBT_OFF_MODE, 32'h1);
    apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
    chk32(rd, 32'h00010000);
    $display("low power done");
    apb(1'b1, `CANSBT_OFF_MASK, 32'h01000000);
    pulse(8);
    repeat (3) @(posedge pclk);
    chk32({31'h0, irq}, 32'h1);
    apb(1'b0, `CANSBT_OFF_STATUS, 32'h0);
    repeat (3) @(posedge pclk);
    chk32({31'h0, irq}, 32'h0);
    apb(1'b1, `CANSBT_OFF_MASK, 32'h0);
    pulse(8);
    repeat (3) @(posedge pclk);
    chk32({31'h0, irq}, 32'h0);
    $display("interrupt done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CANSBT_OFF_TIMING, 32'h0);
    chk32(rd, `CANSBT_BT_RESET);
    $display("second reset done");
    wrap_up();
  end
endmodule
